// *** src/acc_pkg.sv ***
// Purpose: Constants and types for the acquisition completion control block
// Assumes: 32-bit register port, byte addresses on word boundaries
// Notes: Bandwidth limit and bucket count are plain defaults

package acc_pkg;

   // ****************************************
   // Register port
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_AVG_COUNT = 8'h04;
   localparam logic [7:0] REG_COMPLETE = 8'h08;
   localparam logic [7:0] REG_BANDWIDTH = 8'h0C;
   localparam logic [7:0] REG_COMMAND = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_QUERY = 8'h18;
   localparam logic [7:0] REG_RESPONSE = 8'h1C;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int CTRL_AVG_BIT = 0;
   localparam int CTRL_CSTATE_BIT = 1;
   localparam int CTRL_ETIME_BIT = 2;
   localparam int CMD_DEFAULT_BIT = 0;
   localparam int CMD_AUTOSCALE_BIT = 1;
   localparam int CMD_START_BIT = 2;
   localparam int BW_GHZ_LSB = 8;
   localparam int QRY_HDR_BIT = 2;
   localparam int RESP_VALID_BIT = 8;
   localparam int ST_COMPLETE_BIT = 0;
   localparam int ST_RUN_BIT = 1;
   localparam int ST_EFF_CSTATE_BIT = 2;
   localparam int ST_BYPASS_BIT = 3;
   localparam int ST_FULL_LSB = 8;
   localparam int ST_BW_LSB = 16;

   // ****************************************
   // Value ranges and reset values
   // ****************************************
   localparam int CNT_W = 16;
   localparam logic [15:0] AVG_MIN = 16'h0002;
   localparam logic [15:0] AVG_MAX = 16'hFFFE;
   localparam logic [15:0] AVG_RST = 16'h0010;
   localparam logic [15:0] ONE_HIT = 16'h0001;
   localparam logic [6:0] PCT_MAX = 7'h64;
   localparam logic [6:0] PCT_RST = 7'h5A;
   localparam logic [6:0] PCT_AUTOSCALE = 7'h64;
   localparam logic [6:0] PCT_ZERO = 7'h00;
   localparam logic [15:0] PCT_SCALE = 16'h0064;
   localparam logic [7:0] BW_MAX_GHZ = 8'h10;
   localparam logic [7:0] BW_MIN_GHZ = 8'h01;

   // ****************************************
   // Time buckets
   // ****************************************
   localparam int BKT_W = 6;
   localparam int NUM_BUCKETS = 64;
   localparam logic [15:0] NUM_BUCKETS16 = 16'h0040;

   // ****************************************
   // Query responses
   // ****************************************
   localparam int RESP_BYTES = 24;
   localparam int RESP_LEN_W = 5;
   localparam logic [7:0] CHAR_NL = 8'h0A;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [127:0] HDR_COUNT = ":ACQ:COUN ";
   localparam logic [127:0] HDR_COMPLETE = ":ACQ:COMP ";
   localparam logic [127:0] HDR_CSTATE = ":ACQ:COMP:STAT ";
   localparam logic [127:0] HDR_BAND = ":ACQ:BAND ";
   localparam logic [4:0] HDR_COUNT_LEN = 5'h0A;
   localparam logic [4:0] HDR_COMPLETE_LEN = 5'h0A;
   localparam logic [4:0] HDR_CSTATE_LEN = 5'h0F;
   localparam logic [4:0] HDR_BAND_LEN = 5'h0A;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [1:0] {
      BW_AUTO = 2'h0,
      BW_MAX = 2'h1,
      BW_FIXED = 2'h2
   } acc_bw_mode_t;

   typedef enum logic [1:0] {
      Q_COUNT = 2'h0,
      Q_COMPLETE = 2'h1,
      Q_CSTATE = 2'h2,
      Q_BAND = 2'h3
   } acc_qitem_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_DONE = 3'b100
   } acc_state_t;

endpackage : acc_pkg

// *** src/acc_completion_ctrl.sv ***
// Purpose: Averaging count, bandwidth and acquisition completion control
// Assumes: Inputs synchronous to clk_in; one sample hit per cycle at most
// Notes: Query text is pulled a byte at a time from the response register
//
// The register offsets and the plain strobed port were chosen for this implementation.

`timescale 1ns/10ps

// Overview of operation
// - Averaging count accepts only 2 through 65534; others are ignored.
// - With averaging, each bucket collects the configured count before it counts as done.
// - Count query reports the selected count as a decimal integer.
// - Automatic bandwidth follows the sample rate setting.
// - Maximum bandwidth bypasses the filter at the hardware limit.
// - Fixed bandwidth runs from the maximum down to 1 GHz in 1 GHz steps.
// - Completion percentage is an integer 0 through 100 of full buckets.
// - Averaging off: one sample makes a bucket full.
// - Averaging on: a bucket is full after count hits.
// - Real-time: without averaging each trigger refills the record; completion acts as 100 percent.
// - At 100 percent every bucket must hold data before completion.
// - At 0 percent one acquisition cycle completes the acquisition.
// - Default setup loads 90 percent; autoscale loads 100 percent.
// - Completion-mode enable is a 1 or 0 bit that can be read back.
// - Completion-mode enable matters only in equivalent time without digitize.
// - Digitize forces completion mode on while it runs.
// - Completion mode off: measure every cycle, record kept and overwritten.
// - A cycle that adds no points is handled without fault.
module acc_completion_ctrl
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [acc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [acc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [acc_pkg::DATA_W-1:0] reg_rdata_out,
   // Acquisition events
   input wire logic digitize_in,
   input wire logic trigger_in,
   input wire logic cycle_end_in,
   input wire logic sample_valid_in,
   input wire logic [acc_pkg::BKT_W-1:0] sample_bucket_in,
   input wire logic [7:0] srate_gsps_in,
   // Status and filter control
   output logic complete_out,
   output logic measure_out,
   output logic filter_bypass_out,
   output logic [7:0] filter_bw_ghz_out
);
   import acc_pkg::*;

   // ****************************************
   // Settings
   // ****************************************
   logic averaging_enable_q;
   logic cstate_q;
   logic etime_q;
   logic [CNT_W-1:0] avg_count_q;
   logic [6:0] pct_q;
   acc_bw_mode_t bw_mode_q;
   logic [7:0] bw_ghz_q;
   logic [DATA_W-1:0] reg_rdata_q;
   logic wr_ctrl;
   logic wr_cmd;
   logic start;

   assign wr_ctrl = reg_wr_in && (reg_addr_in == REG_CTRL);
   assign wr_cmd = reg_wr_in && (reg_addr_in == REG_COMMAND);
   assign start = wr_cmd && reg_wdata_in[CMD_START_BIT];

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         averaging_enable_q <= 1'b0;
         cstate_q <= 1'b1;
         etime_q <= 1'b0;
      end
      else if (wr_ctrl)
      begin
         averaging_enable_q <= reg_wdata_in[CTRL_AVG_BIT];
         cstate_q <= reg_wdata_in[CTRL_CSTATE_BIT];
         etime_q <= reg_wdata_in[CTRL_ETIME_BIT];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         avg_count_q <= AVG_RST;
      end
      else if (reg_wr_in && (reg_addr_in == REG_AVG_COUNT) &&
               (reg_wdata_in[CNT_W-1:0] >= AVG_MIN) &&
               (reg_wdata_in[CNT_W-1:0] <= AVG_MAX) &&
               (reg_wdata_in[DATA_W-1:CNT_W] == '0))
      begin
         avg_count_q <= reg_wdata_in[CNT_W-1:0];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         pct_q <= PCT_RST;
      end
      else if (wr_cmd && reg_wdata_in[CMD_AUTOSCALE_BIT])
      begin
         pct_q <= PCT_AUTOSCALE;
      end
      else if (wr_cmd && reg_wdata_in[CMD_DEFAULT_BIT])
      begin
         pct_q <= PCT_RST;
      end
      else if (reg_wr_in && (reg_addr_in == REG_COMPLETE) &&
               (reg_wdata_in[DATA_W-1:7] == '0) && (reg_wdata_in[6:0] <= PCT_MAX))
      begin
         pct_q <= reg_wdata_in[6:0];
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         bw_mode_q <= BW_AUTO;
         bw_ghz_q <= BW_MAX_GHZ;
      end
      else if (reg_wr_in && (reg_addr_in == REG_BANDWIDTH))
      begin
         if (reg_wdata_in[1:0] == BW_FIXED)
         begin
            if ((reg_wdata_in[BW_GHZ_LSB +: 8] >= BW_MIN_GHZ) &&
                (reg_wdata_in[BW_GHZ_LSB +: 8] <= BW_MAX_GHZ))
            begin
               bw_mode_q <= BW_FIXED;
               bw_ghz_q <= reg_wdata_in[BW_GHZ_LSB +: 8];
            end
         end
         else if (reg_wdata_in[1:0] == BW_MAX)
         begin
            bw_mode_q <= BW_MAX;
         end
         else if (reg_wdata_in[1:0] == BW_AUTO)
         begin
            bw_mode_q <= BW_AUTO;
         end
      end
   end

   // ****************************************
   // Bandwidth filter
   // ****************************************
   logic [7:0] auto_ghz;
   logic [7:0] bw_eff;

   always_comb
   begin
      auto_ghz = {1'b0, srate_gsps_in[7:1]};
      if (auto_ghz < BW_MIN_GHZ)
      begin
         auto_ghz = BW_MIN_GHZ;
      end
      else if (auto_ghz > BW_MAX_GHZ)
      begin
         auto_ghz = BW_MAX_GHZ;
      end
      case (bw_mode_q)
         BW_AUTO: bw_eff = auto_ghz;
         BW_MAX: bw_eff = BW_MAX_GHZ;
         BW_FIXED: bw_eff = bw_ghz_q;
         default: bw_eff = BW_MAX_GHZ;
      endcase
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         filter_bypass_out <= 1'b0;
         filter_bw_ghz_out <= BW_MAX_GHZ;
      end
      else
      begin
         filter_bypass_out <= (bw_mode_q == BW_MAX);
         filter_bw_ghz_out <= bw_eff;
      end
   end

   // ****************************************
   // Effective completion settings
   // ****************************************
   logic eff_cstate;
   logic [6:0] eff_pct;
   logic [CNT_W-1:0] target;

   // Real time always behaves as full completion
   assign eff_cstate = digitize_in || !etime_q || cstate_q;
   assign eff_pct = etime_q ? pct_q : PCT_MAX;
   assign target = averaging_enable_q ? avg_count_q : ONE_HIT;

   // ****************************************
   // Time bucket fill tracking
   // ****************************************
   acc_state_t state_q;
   logic [CNT_W-1:0] hits_q [0:NUM_BUCKETS-1];
   logic [BKT_W:0] full_cnt_q;
   logic clear_rec;
   logic [CNT_W-1:0] hit_cur;
   logic met;

   // Real-time without averaging: each trigger replaces the record
   assign clear_rec = start ||
                      (!etime_q && !averaging_enable_q && trigger_in);
   assign hit_cur = hits_q[sample_bucket_in];
   assign met = ({9'h000, full_cnt_q} * PCT_SCALE) >=
                ({9'h000, eff_pct} * NUM_BUCKETS16);

   always_ff @(posedge clk_in)
   begin
      if (srst_in || clear_rec)
      begin
         for (int i = 0; i < NUM_BUCKETS; i++)
         begin
            hits_q[i] <= '0;
         end
         full_cnt_q <= '0;
      end
      else if (sample_valid_in && (state_q == ST_RUN) && (hit_cur < target))
      begin
         hits_q[sample_bucket_in] <= hit_cur + ONE_HIT;
         if ((hit_cur + ONE_HIT) == target)
         begin
            full_cnt_q <= full_cnt_q + 1'b1;
         end
      end
   end

   // ****************************************
   // Acquisition sequencing
   // ****************************************
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         state_q <= ST_IDLE;
         complete_out <= 1'b0;
         measure_out <= 1'b0;
      end
      else
      begin
         measure_out <= 1'b0;
         if (start)
         begin
            state_q <= ST_RUN;
            complete_out <= 1'b0;
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  state_q <= ST_IDLE;
               end
               ST_RUN:
               begin
                  // Cycle end may carry no new points at all
                  if (cycle_end_in)
                  begin
                     if (!eff_cstate)
                     begin
                        measure_out <= 1'b1;
                     end
                     else if ((eff_pct == PCT_ZERO) || met)
                     begin
                        measure_out <= 1'b1;
                        complete_out <= 1'b1;
                        state_q <= ST_DONE;
                     end
                  end
               end
               ST_DONE:
               begin
                  state_q <= ST_DONE;
               end
               default:
               begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ****************************************
   // Query text builder
   // ****************************************
   function automatic logic [19:0] to_bcd(input logic [15:0] bin);
      logic [19:0] bcd;
      bcd = '0;
      for (int i = 15; i >= 0; i--)
      begin
         for (int d = 0; d < 5; d++)
         begin
            if (bcd[d*4 +: 4] > 4'h4)
            begin
               bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
            end
         end
         bcd = {bcd[18:0], bin[i]};
      end
      return bcd;
   endfunction : to_bcd

   logic [RESP_BYTES*8-1:0] resp_q;
   logic [RESP_BYTES*8-1:0] resp_d;
   logic [RESP_LEN_W-1:0] resp_len_q;
   logic [RESP_LEN_W-1:0] resp_len_d;
   logic [RESP_LEN_W-1:0] resp_pos_q;
   logic [15:0] q_value;
   logic [127:0] q_hdr;
   logic [4:0] q_hdr_len;
   logic [19:0] q_bcd;
   logic q_started;
   logic wr_query;
   logic rd_resp;
   logic resp_avail;

   assign wr_query = reg_wr_in && (reg_addr_in == REG_QUERY);
   assign rd_resp = reg_rd_in && (reg_addr_in == REG_RESPONSE);
   assign resp_avail = resp_pos_q < resp_len_q;

   always_comb
   begin
      case (reg_wdata_in[1:0])
         Q_COUNT:
         begin
            q_value = avg_count_q;
            q_hdr = HDR_COUNT;
            q_hdr_len = HDR_COUNT_LEN;
         end
         Q_COMPLETE:
         begin
            q_value = {9'h000, pct_q};
            q_hdr = HDR_COMPLETE;
            q_hdr_len = HDR_COMPLETE_LEN;
         end
         Q_CSTATE:
         begin
            q_value = {15'h0000, cstate_q};
            q_hdr = HDR_CSTATE;
            q_hdr_len = HDR_CSTATE_LEN;
         end
         default:
         begin
            q_value = {8'h00, bw_eff};
            q_hdr = HDR_BAND;
            q_hdr_len = HDR_BAND_LEN;
         end
      endcase
      q_bcd = to_bcd(q_value);
      resp_d = '0;
      resp_len_d = '0;
      q_started = 1'b0;
      if (reg_wdata_in[QRY_HDR_BIT])
      begin
         for (int i = 0; i < 16; i++)
         begin
            if (5'(i) < q_hdr_len)
            begin
               resp_d[resp_len_d*8 +: 8] = q_hdr[(q_hdr_len - 5'(i) - 5'h01)*8 +: 8];
               resp_len_d = resp_len_d + 1'b1;
            end
         end
      end
      // Decimal digits without leading zeros
      for (int d = 4; d >= 0; d--)
      begin
         if (q_started || (q_bcd[d*4 +: 4] != 4'h0) || (d == 0))
         begin
            q_started = 1'b1;
            resp_d[resp_len_d*8 +: 8] = CHAR_ZERO + {4'h0, q_bcd[d*4 +: 4]};
            resp_len_d = resp_len_d + 1'b1;
         end
      end
      resp_d[resp_len_d*8 +: 8] = CHAR_NL;
      resp_len_d = resp_len_d + 1'b1;
   end

   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         resp_q <= '0;
         resp_len_q <= '0;
         resp_pos_q <= '0;
      end
      else if (wr_query)
      begin
         resp_q <= resp_d;
         resp_len_q <= resp_len_d;
         resp_pos_q <= '0;
      end
      else if (rd_resp && resp_avail)
      begin
         resp_pos_q <= resp_pos_q + 1'b1;
      end
   end

   // ****************************************
   // Register read
   // ****************************************
   always_ff @(posedge clk_in)
   begin
      if (srst_in)
      begin
         reg_rdata_q <= '0;
      end
      else if (reg_rd_in)
      begin
         reg_rdata_q <= '0;
         case (reg_addr_in)
            REG_CTRL:
            begin
               reg_rdata_q[CTRL_AVG_BIT] <= averaging_enable_q;
               reg_rdata_q[CTRL_CSTATE_BIT] <= cstate_q;
               reg_rdata_q[CTRL_ETIME_BIT] <= etime_q;
            end
            REG_AVG_COUNT: reg_rdata_q[CNT_W-1:0] <= avg_count_q;
            REG_COMPLETE: reg_rdata_q[6:0] <= pct_q;
            REG_BANDWIDTH:
            begin
               reg_rdata_q[1:0] <= bw_mode_q;
               reg_rdata_q[BW_GHZ_LSB +: 8] <= bw_ghz_q;
            end
            REG_STATUS:
            begin
               reg_rdata_q[ST_COMPLETE_BIT] <= complete_out;
               reg_rdata_q[ST_RUN_BIT] <= (state_q == ST_RUN);
               reg_rdata_q[ST_EFF_CSTATE_BIT] <= eff_cstate;
               reg_rdata_q[ST_BYPASS_BIT] <= filter_bypass_out;
               reg_rdata_q[ST_FULL_LSB +: BKT_W+1] <= full_cnt_q;
               reg_rdata_q[ST_BW_LSB +: 8] <= bw_eff;
            end
            REG_RESPONSE:
            begin
               reg_rdata_q[RESP_VALID_BIT] <= resp_avail;
               reg_rdata_q[7:0] <= resp_avail ? resp_q[resp_pos_q*8 +: 8] : 8'h00;
            end
            default: reg_rdata_q <= '0;
         endcase
      end
      else
      begin
         reg_rdata_q <= '0;
      end
   end

   assign reg_rdata_out = reg_rdata_q;

endmodule : acc_completion_ctrl

// *** sim/acc_monitor.sv ***
// Purpose: Port checker for completion control
// Assumes: One clock domain
// Notes: Bound from the bench top
`timescale 1ns/10ps
module acc_monitor
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic srst_in,
   // Register port
   input wire logic [acc_pkg::ADDR_W-1:0] reg_addr_in,
   input wire logic [acc_pkg::DATA_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [acc_pkg::DATA_W-1:0] reg_rdata_out,
   // Acquisition
   input wire logic digitize_in,
   input wire logic trigger_in,
   input wire logic cycle_end_in,
   input wire logic sample_valid_in,
   input wire logic [acc_pkg::BKT_W-1:0] sample_bucket_in,
   input wire logic [7:0] srate_gsps_in,
   input wire logic complete_out,
   input wire logic measure_out,
   input wire logic filter_bypass_out,
   input wire logic [7:0] filter_bw_ghz_out
);
   import acc_pkg::*;
   logic start_cmd;
   assign start_cmd = reg_wr_in && reg_addr_in == REG_COMMAND && reg_wdata_in[CMD_START_BIT];
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   // ****************************************
   // Assertions
   // ****************************************
   chk_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == '0)
      else $error("read data outside read slot");
   chk_wo_read: assert property (reg_rd_in && (reg_addr_in == REG_COMMAND
      || reg_addr_in > REG_RESPONSE) |=> reg_rdata_out == '0)
      else $error("write-only or unmapped read not zero");
   chk_measure_cause: assert property (measure_out |-> $past(cycle_end_in))
      else $error("measure without cycle end");
   chk_complete_meas: assert property ($rose(complete_out) |-> measure_out)
      else $error("complete without measure");
   chk_complete_end: assert property ($rose(complete_out) |-> $past(cycle_end_in))
      else $error("complete not at cycle end");
   chk_complete_hold: assert property (complete_out && !start_cmd |=> complete_out)
      else $error("complete dropped");
   chk_start_clear: assert property (start_cmd |=> !complete_out)
      else $error("start kept complete");
   chk_bypass_max: assert property (filter_bypass_out |-> filter_bw_ghz_out == BW_MAX_GHZ)
      else $error("bypass below limit");
   chk_bw_range: assert property (filter_bw_ghz_out inside {[BW_MIN_GHZ:BW_MAX_GHZ]})
      else $error("bandwidth out of range");
   cover property ($rose(complete_out));
   cover property (measure_out && !complete_out);
   cover property (filter_bypass_out);
endmodule : acc_monitor

// *** sim/acc_host.sv ***
// Purpose: Host model issuing register accesses
// Assumes: Slave never stalls
// Notes: One strobe cycle per access
`timescale 1ns/10ps
module acc_host
(
   // Clock
   input wire logic clk_in,
   // Register port
   output logic [acc_pkg::ADDR_W-1:0] addr_out,
   output logic [acc_pkg::DATA_W-1:0] wdata_out,
   output logic wr_out,
   output logic rd_out,
   input wire logic [acc_pkg::DATA_W-1:0] rdata_in
);
   import acc_pkg::*;
   initial
   begin
      addr_out = '0;
      wdata_out = '0;
      wr_out = 1'b0;
      rd_out = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      wdata_out <= d;
      wr_out <= 1'b1;
      @(posedge clk_in);
      wr_out <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_in);
      addr_out <= a;
      rd_out <= 1'b1;
      @(posedge clk_in);
      rd_out <= 1'b0;
      #1;
      d = rdata_in;
   endtask : rd
endmodule : acc_host

// *** sim/acquisition_completion_control_test.sv ***
// Purpose: Self-checking bench for completion control
// Assumes: Host model drives the register port
// Notes: Model keeps bucket hits in an int array
`timescale 1ns/10ps
module acquisition_completion_control_test;
   import acc_pkg::*;
   logic clk_in, srst_in, reg_wr_in, reg_rd_in, digitize_in, trigger_in;
   logic cycle_end_in, sample_valid_in, complete_out, measure_out, filter_bypass_out;
   logic [7:0] reg_addr_in, srate_gsps_in, filter_bw_ghz_out;
   logic [31:0] reg_wdata_in, reg_rdata_out;
   logic [5:0] sample_bucket_in;
   int fail_count = 0;
   int num_checks = 0;
   int hits_m[64];
   int avg_m, et_m, cs_m, cnt_m, pct_m, e, run_m;
   acc_host i_acc_host (.clk_in(clk_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
      .wr_out(reg_wr_in), .rd_out(reg_rd_in), .rdata_in(reg_rdata_out));
   acc_completion_ctrl i_acc_completion_ctrl (.clk_in(clk_in), .srst_in(srst_in),
      .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .digitize_in(digitize_in),
      .trigger_in(trigger_in), .cycle_end_in(cycle_end_in), .sample_valid_in(sample_valid_in),
      .sample_bucket_in(sample_bucket_in), .srate_gsps_in(srate_gsps_in),
      .complete_out(complete_out), .measure_out(measure_out),
      .filter_bypass_out(filter_bypass_out), .filter_bw_ghz_out(filter_bw_ghz_out));
   initial
   begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
      num_checks++;
      if (g !== ex)
      begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", nm, ex, g);
      end
   endtask : chk
   task automatic rchk(input string nm, input logic [7:0] a, input int ex);
      logic [31:0] d;
      i_acc_host.rd(a, d);
      chk(nm, ex, d);
   endtask : rchk
   task automatic qchk(input logic [2:0] q, input string s);
      logic [31:0] d;
      i_acc_host.wr(REG_QUERY, {29'h0, q});
      for (int i = 0; i <= s.len(); i++)
      begin
         i_acc_host.rd(REG_RESPONSE, d);
         chk("response", (i < s.len()) ? {23'h0, 1'b1, s[i]} : 32'h0, d);
      end
   endtask : qchk
   task automatic cfg(input int a, input int et, input int cs, input int c, input int p);
      i_acc_host.wr(REG_CTRL, (et << 2) | (cs << 1) | a);
      i_acc_host.wr(REG_AVG_COUNT, c);
      i_acc_host.wr(REG_COMPLETE, p);
      i_acc_host.wr(REG_COMMAND, 32'h4);
      {avg_m, et_m, cs_m, cnt_m, pct_m} = {a, et, cs, c, p};
      run_m = 1;
      hits_m = '{default: 0};
   endtask : cfg
   task automatic acq(input int f, input int n, input int h, input logic trg, input logic dig);
      int tgt, full, met, eff;
      tgt = avg_m ? cnt_m : 1;
      full = 0;
      @(posedge clk_in);
      digitize_in <= dig;
      trigger_in <= trg;
      @(posedge clk_in);
      trigger_in <= 1'b0;
      if (trg && !et_m && !avg_m)
         hits_m = '{default: 0};
      for (int b = f; b < f + n; b++)
      begin
         for (int k = 0; k < h; k++)
         begin
            sample_valid_in <= 1'b1;
            sample_bucket_in <= b[5:0];
            @(posedge clk_in);
            if (run_m && hits_m[b] < tgt)
               hits_m[b]++;
         end
      end
      sample_valid_in <= 1'b0;
      cycle_end_in <= 1'b1;
      @(posedge clk_in);
      cycle_end_in <= 1'b0;
      #1;
      foreach (hits_m[b])
         full += (hits_m[b] >= tgt);
      met = (et_m && pct_m == 0) || full * 100 >= (et_m ? pct_m : 100) * 64;
      eff = dig || !et_m || cs_m;
      chk("measure", run_m && (!eff || met), measure_out);
      run_m = run_m && !(eff && met);
      chk("complete", !run_m, complete_out);
      digitize_in <= 1'b0;
   endtask : acq
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   initial
   begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      wrap_up();
   end
   initial
   begin
      int vals[5];
      {srst_in, digitize_in, trigger_in, cycle_end_in, sample_valid_in} = 5'h10;
      sample_bucket_in = 6'h00;
      srate_gsps_in = 8'h28;
      void'($urandom(61));
      repeat (20) @(posedge clk_in);
      srst_in <= 1'b0;
      rchk("ctrl", REG_CTRL, 2);
      rchk("count", REG_AVG_COUNT, 16);
      rchk("pct", REG_COMPLETE, 90);
      rchk("unmapped", 8'h20, 0);
      $display("reset values done");
      vals = '{1, 2, 65534, 65535, 32'h10003};
      e = 16;
      foreach (vals[i])
      begin
         i_acc_host.wr(REG_AVG_COUNT, vals[i]);
         e = (vals[i] >= 2 && vals[i] <= 65534) ? vals[i] : e;
         rchk("count", REG_AVG_COUNT, e);
      end
      qchk(3'h0, "65534\n");
      vals = '{101, 0, 100, 60, 127};
      e = 90;
      foreach (vals[i])
      begin
         i_acc_host.wr(REG_COMPLETE, vals[i]);
         e = (vals[i] <= 100) ? vals[i] : e;
         rchk("pct", REG_COMPLETE, e);
      end
      qchk(3'h5, ":ACQ:COMP 60\n");
      vals = '{1, 3, 2, 1, 0};
      foreach (vals[i])
      begin
         i_acc_host.wr(REG_COMMAND, vals[i]);
         e = vals[i][1] ? 100 : (vals[i][0] ? 90 : e);
         rchk("pct", REG_COMPLETE, e);
      end
      rchk("command", REG_COMMAND, 0);
      $display("settings done");
      for (int i = 0; i < 5; i++)
      begin
         @(posedge clk_in);
         srate_gsps_in <= 8'($urandom() % 41);
         repeat (3) @(posedge clk_in);
         #1;
         e = (srate_gsps_in / 2 < 1) ? 1 : ((srate_gsps_in / 2 > 16) ? 16 : srate_gsps_in / 2);
         chk("auto bw", e, filter_bw_ghz_out);
      end
      i_acc_host.wr(REG_BANDWIDTH, 1);
      repeat (2) @(posedge clk_in);
      #1;
      chk("bypass", 1, filter_bypass_out);
      chk("max bw", BW_MAX_GHZ, filter_bw_ghz_out);
      for (int g = 0; g < 18; g++)
      begin
         i_acc_host.wr(REG_BANDWIDTH, (g << 8) | 2);
         repeat (2) @(posedge clk_in);
         #1;
         e = (g >= 1 && g <= 16) ? g : ((g == 0) ? 16 : e);
         chk("fixed bw", e, filter_bw_ghz_out);
         chk("bypass", g == 0, filter_bypass_out);
      end
      qchk(3'h3, "16\n");
      $display("bandwidth done");
      cfg(0, 1, 1, 2, 100);
      acq(0, 63, 1, 1'b1, 1'b0);
      acq(63, 1, 1, 1'b1, 1'b0);
      cfg(0, 1, 1, 2, 0);
      acq(0, 0, 0, 1'b1, 1'b0);
      cfg(1, 1, 1, 3, 50);
      acq(0, 32, 2, 1'b1, 1'b0);
      acq(0, 32, 1, 1'b1, 1'b0);
      cfg(0, 1, 0, 2, 0);
      acq(0, 5, 1, 1'b1, 1'b0);
      acq(5, 0, 0, 1'b1, 1'b1);
      cfg(0, 0, 0, 2, 10);
      acq(0, 40, 1, 1'b1, 1'b0);
      acq(40, 24, 1, 1'b1, 1'b0);
      rchk("status", REG_STATUS, (16 << 16) | (24 << 8) | 6);
      qchk(3'h2, "0\n");
      $display("acquisition done");
      wrap_up();
   end
endmodule : acquisition_completion_control_test
bind acc_completion_ctrl acc_monitor i_acc_monitor (.clk_in(clk_in), .srst_in(srst_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .digitize_in(digitize_in),
   .trigger_in(trigger_in), .cycle_end_in(cycle_end_in), .sample_valid_in(sample_valid_in),
   .sample_bucket_in(sample_bucket_in), .srate_gsps_in(srate_gsps_in),
   .complete_out(complete_out), .measure_out(measure_out),
   .filter_bypass_out(filter_bypass_out), .filter_bw_ghz_out(filter_bw_ghz_out));
